/* rtl/csbt_pkg.sv */
// Shared constants for the chip-select bus cycle timer.
package csbt_pkg;
  localparam int NCS = 5;
  localparam int TMG_W = 16;
  // Field positions of select_timing_reg.
  localparam int TF_CHG = 0;
  localparam int TF_SET = 2;
  localparam int TF_DLY = 3;
  localparam int TF_DS = 5;
  localparam int TF_CMD = 6;
  localparam int TF_RH = 11;
  localparam int TF_WH = 13;
  localparam int LEN_W = 6;
  localparam logic [1:0] IDLE_SAT = 2'h3;
  typedef enum logic [2:0] {
    PH_IDLE, PH_CHG, PH_SET, PH_DLY, PH_DS, PH_CMD, PH_HOLD
  } csbt_ph_t;
endpackage

/* rtl/csbt_cycle_timer.sv */
// Chip-select decode and bus-cycle phase sequencer.
`timescale 1ns/1ps
`default_nettype none
module csbt_cycle_timer
  import csbt_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NCS-1:0] strap_cs_en,
  input wire logic mux_mode,
  input wire logic ready_en,
  input wire logic [NCS-1:0][AW-1:0] select_region_base,
  input wire logic [NCS-1:0][AW-1:0] select_region_mask,
  input wire logic [NCS-1:0] select_function_en,
  input wire logic [NCS-1:0][TMG_W-1:0] select_timing_reg,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [AW-1:0] req_addr,
  input wire logic req_write,
  input wire logic [DW-1:0] req_wdata,
  output logic resp_valid,
  output logic [DW-1:0] resp_rdata,
  output logic [AW-1:0] bus_addr,
  output logic bus_ale,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic [NCS-1:0] chip_select_n,
  output logic [DW-1:0] bus_ad_out,
  output logic bus_ad_oe,
  input wire logic [DW-1:0] bus_ad_in,
  input wire logic bus_ready
);
  csbt_ph_t phase_ff;
  csbt_ph_t nxt_phase;
  logic [LEN_W-1:0] len_ff [1:6];
  logic [LEN_W-1:0] cnt_ff;
  logic [2:0] cur_cs_ff, last_cs_ff;
  logic [1:0] last_chg_ff;
  logic [1:0] idle_ff;
  logic write_ff;
  logic [AW-1:0] addr_ff;
  logic [DW-1:0] wdata_ff;
  logic [NCS-1:0] strap_s1_ff, strap_s2_ff, strap_ff;
  logic [DW-1:0] din_s1_ff, din_s2_ff;
  logic rdy_s1_ff, rdy_s2_ff;
  logic [NCS-1:0] cs_live;
  logic [2:0] hit_cs;
  logic [TMG_W-1:0] tmg;
  logic [1:0] chg_eff;
  logic start, ph_end, cmd_end;

  // Pins from outside pass two flops before any logic reads them.
  always_ff @(posedge clk) begin
    strap_s1_ff <= strap_cs_en;
    strap_s2_ff <= strap_s1_ff;
    din_s1_ff <= bus_ad_in;
    din_s2_ff <= din_s1_ff;
    rdy_s1_ff <= bus_ready;
    rdy_s2_ff <= rdy_s1_ff;
  end

  // Straps are caught while reset is held, so they must be stable by then.
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_ff <= strap_s2_ff;
    end
  end

  // Selects 1..4 need both strap and function enable; lowest index wins.
  always_comb begin
    cs_live = strap_ff & select_function_en;
    hit_cs = 3'h0;
    for (int i = NCS - 1; i >= 1; i--) begin
      if (cs_live[i] && ((req_addr ^ select_region_base[i])
          & select_region_mask[i]) == '0) begin
        hit_cs = 3'(i);
      end
    end
  end

  assign tmg = select_timing_reg[hit_cs];
  assign req_ready = (phase_ff == PH_IDLE);
  assign start = req_valid && req_ready;

  // Change clocks come from the previous select, less idle clocks seen.
  always_comb begin
    if (hit_cs == last_cs_ff || idle_ff >= last_chg_ff) begin
      chg_eff = 2'h0;
    end else begin
      chg_eff = last_chg_ff - idle_ff;
    end
  end

  assign cmd_end = (phase_ff == PH_CMD) && cnt_ff == '0
                   && (!ready_en || rdy_s2_ff);
  assign ph_end = (phase_ff == PH_CMD) ? cmd_end : (cnt_ff == '0);

  function automatic csbt_ph_t pick(input int from,
                                    input logic [LEN_W-1:0] l [1:6]);
    csbt_ph_t r;
    r = PH_IDLE;
    for (int i = 6; i >= 1; i--) begin
      if (i >= from && l[i] != '0) begin
        r = csbt_ph_t'(i);
      end
    end
    return r;
  endfunction

  logic [LEN_W-1:0] new_len [1:6];
  always_comb begin
    new_len[1] = LEN_W'(chg_eff);
    new_len[2] = LEN_W'(tmg[TF_SET]) + 6'h01;
    new_len[3] = LEN_W'(tmg[TF_DLY +: 2]);
    new_len[4] = LEN_W'(tmg[TF_DS]);
    new_len[5] = LEN_W'(tmg[TF_CMD +: 5]) + 6'h01;
    new_len[6] = req_write ? LEN_W'(tmg[TF_WH +: 2])
                           : LEN_W'(tmg[TF_RH +: 2]);
  end

  always_comb begin
    nxt_phase = phase_ff;
    if (start) begin
      nxt_phase = pick(1, new_len);
    end else if (phase_ff != PH_IDLE && ph_end) begin
      nxt_phase = pick(int'(phase_ff) + 1, len_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= PH_IDLE;
      cnt_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
      if (nxt_phase != PH_IDLE && (start || ph_end)) begin
        cnt_ff <= (start ? new_len[int'(nxt_phase)]
                         : len_ff[int'(nxt_phase)]) - 6'h01;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 6'h01;
      end
    end
  end

  // Lengths and access data are frozen for the whole access.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 1; i <= 6; i++) begin
        len_ff[i] <= '0;
      end
      cur_cs_ff <= 3'h0;
      write_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
    end else if (start) begin
      len_ff <= new_len;
      cur_cs_ff <= hit_cs;
      write_ff <= req_write;
      addr_ff <= req_addr;
      wdata_ff <= req_wdata;
    end
  end

  // The change length of a finished access is kept for the next switch.
  always_ff @(posedge clk) begin
    if (rst) begin
      last_cs_ff <= 3'h0;
      last_chg_ff <= 2'h0;
      idle_ff <= 2'h0;
    end else if (start) begin
      last_cs_ff <= hit_cs;
      last_chg_ff <= tmg[TF_CHG +: 2];
      idle_ff <= 2'h0;
    end else if (phase_ff == PH_IDLE && idle_ff != IDLE_SAT) begin
      idle_ff <= idle_ff + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_rdata <= '0;
    end else begin
      resp_valid <= ph_end && phase_ff != PH_IDLE
                    && nxt_phase == PH_IDLE;
      // The pin value is two clocks old here, so a slow device needs a
      // command phase long enough to cover the synchroniser delay.
      if (cmd_end && !write_ff) begin
        resp_rdata <= din_s2_ff;
      end
    end
  end

  // Bus pins follow the phase; the address leads during change clocks.
  always_comb begin
    bus_addr = (phase_ff == PH_IDLE) ? '0 : addr_ff;
    bus_ale = (phase_ff == PH_CHG || phase_ff == PH_SET);
    bus_rd_n = !(phase_ff == PH_CMD && !write_ff);
    bus_wr_n = !(phase_ff == PH_CMD && write_ff);
    chip_select_n = '1;
    if (phase_ff > PH_CHG) begin
      chip_select_n[cur_cs_ff] = 1'b0;
    end
    bus_ad_out = '0;
    bus_ad_oe = 1'b0;
    if (mux_mode && phase_ff inside {PH_CHG, PH_SET, PH_DLY}) begin
      bus_ad_out = addr_ff[DW-1:0];
      bus_ad_oe = 1'b1;
    end else if (write_ff && phase_ff >= PH_DS) begin
      bus_ad_out = wdata_ff;
      bus_ad_oe = 1'b1;
    end
  end

  // Helper count of command-phase clocks for assertions.
  logic [LEN_W-1:0] a_cmd_cnt;
  always_ff @(posedge clk) begin
    if (rst || phase_ff != PH_CMD) begin
      a_cmd_cnt <= '0;
    end else begin
      a_cmd_cnt <= a_cmd_cnt + 6'h01;
    end
  end

  a_cs_onehot: assert property (
    @(posedge clk) disable iff (rst)
    $countones(~chip_select_n) <= 1)
    else $error("more than one select active");

  a_strap_gate: assert property (
    @(posedge clk) disable iff (rst)
    (phase_ff > PH_CHG) |-> (cur_cs_ff == 3'h0 || strap_ff[cur_cs_ff]))
    else $error("select used without strap enable");

  a_chg_switch: assert property (
    @(posedge clk) disable iff (rst)
    (start && hit_cs == last_cs_ff) |=> phase_ff != PH_CHG)
    else $error("change phase on same select");

  a_ale_setup: assert property (
    @(posedge clk) disable iff (rst)
    (phase_ff == PH_DLY || phase_ff == PH_CMD) |-> !bus_ale)
    else $error("latch enable high after setup");

  a_strobe_cmd: assert property (
    @(posedge clk) disable iff (rst)
    (!bus_rd_n || !bus_wr_n) |-> phase_ff == PH_CMD)
    else $error("strobe outside command phase");

  a_cmd_len: assert property (
    @(posedge clk) disable iff (rst)
    ($fell(phase_ff == PH_CMD) && !ready_en)
      |-> $past(a_cmd_cnt) == len_ff[5] - 6'h01)
    else $error("command phase length wrong");

  a_ready_hold: assert property (
    @(posedge clk) disable iff (rst)
    (phase_ff == PH_CMD && ready_en && !rdy_s2_ff) |=> phase_ff == PH_CMD)
    else $error("command ended without ready");

  a_read_cap: assert property (
    @(posedge clk) disable iff (rst)
    (cmd_end && !write_ff) |=> resp_rdata == $past(din_s2_ff))
    else $error("read data not captured");

  a_len_stable: assert property (
    @(posedge clk) disable iff (rst)
    (phase_ff != PH_IDLE && !start) |=> $stable(len_ff[5]))
    else $error("lengths changed mid access");

  a_phase_order: assert property (
    @(posedge clk) disable iff (rst)
    (phase_ff != PH_IDLE && nxt_phase != PH_IDLE && !start)
      |-> nxt_phase >= phase_ff)
    else $error("phases out of order");
endmodule
`default_nettype wire

/* tb/csbt_mem_model.sv */
// Behavioural external memory with a ready line that can stall.
`timescale 1ns/1ps
`default_nettype none
module csbt_mem_model (
  input wire logic clk,
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [4:0] chip_select_n,
  input wire logic [15:0] bus_ad_out,
  input wire logic [3:0] stall,
  output logic [15:0] bus_ad_in,
  output logic bus_ready
);
  logic [15:0] mem [0:255];
  logic [15:0] last_ff = 16'h0;
  logic [3:0] wait_ff = 4'h0;
  wire logic sel = ~&chip_select_n;
  wire logic [7:0] idx = {bus_addr[23:20], bus_addr[3:0]};
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0;
  // An unselected bus shows a value that changes every cycle.
  assign bus_ad_in = (sel && bus_wr_n) ? mem[idx] : ~last_ff;
  assign bus_ready = (wait_ff == 4'h0);
  always @(posedge clk) begin
    last_ff <= bus_ad_in;
    if (sel && !bus_wr_n) mem[idx] <= bus_ad_out;
    if (bus_rd_n && bus_wr_n) wait_ff <= stall;
    else if (wait_ff != 4'h0) wait_ff <= wait_ff - 4'h1;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the chip-select bus cycle timer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import csbt_pkg::*;
  logic clk = 0, rst = 1, mux_mode = 0, ready_en = 0;
  logic req_valid = 0, req_write = 0;
  logic [NCS-1:0] strap_cs_en = 5'h0F, select_function_en = 5'h00;
  logic [NCS-1:0][23:0] select_region_base, select_region_mask;
  logic [NCS-1:0][TMG_W-1:0] select_timing_reg;
  logic [23:0] req_addr = 24'h0, bus_addr;
  logic [15:0] req_wdata = 16'h0, resp_rdata, bus_ad_out, bus_ad_in;
  logic req_ready, resp_valid, bus_ale, bus_rd_n, bus_wr_n;
  logic bus_ad_oe, bus_ready;
  logic [NCS-1:0] chip_select_n;
  logic [3:0] stall = 4'h0;
  logic [15:0] shadow [0:255];
  int errors = 0, check_count = 0, cycles = 0, prev = 0;
  always #4 clk = ~clk;
  csbt_cycle_timer #(.AW(24), .DW(16)) dut (.clk, .rst, .strap_cs_en,
    .mux_mode, .ready_en, .select_region_base, .select_region_mask,
    .select_function_en, .select_timing_reg, .req_valid, .req_ready,
    .req_addr, .req_write, .req_wdata, .resp_valid, .resp_rdata, .bus_addr,
    .bus_ale, .bus_rd_n, .bus_wr_n, .chip_select_n, .bus_ad_out, .bus_ad_oe,
    .bus_ad_in, .bus_ready);
  csbt_mem_model mem (.clk, .bus_addr, .bus_rd_n, .bus_wr_n, .chip_select_n,
    .bus_ad_out, .stall, .bus_ad_in, .bus_ready);
  function automatic logic [15:0] tmg(int c, s, d, ds, cm, rh, wh);
    return {1'b0, wh[1:0], rh[1:0], 5'(cm - 1), ds[0], d[1:0], 1'(s - 1),
      c[1:0]};
  endfunction
  function automatic int lat(logic [15:0] t, logic w);
    return t[2] + 1 + t[4:3] + t[5] + t[10:6] + 1 + (w ? t[14:13] : t[12:11]);
  endfunction
  function automatic int sel_of(logic [23:0] a);
    for (int i = 1; i < NCS; i++)
      if (select_function_en[i] && strap_cs_en[i] && a[23:20] == i) return i;
    return 0;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The gap is the number of idle cycles left before the request is raised.
  task automatic acc(logic [23:0] a, logic w, int gap);
    int n, s, e, cmdc;
    logic [NCS-1:0] seen;
    logic [7:0] k;
    logic bad;
    s = sel_of(a);
    k = {a[23:20], a[3:0]};
    e = lat(select_timing_reg[s], w);
    if (s != prev && select_timing_reg[prev][1:0] > gap)
      e += select_timing_reg[prev][1:0] - gap;
    repeat (gap) begin
      @(posedge clk);
      #1;
    end
    req_addr = a;
    req_write = w;
    req_wdata = 16'($urandom);
    req_valid = 1;
    if (w) shadow[k] = req_wdata;
    do @(posedge clk); while (req_ready !== 1'b1);
    #1 req_valid = 0;
    seen = '1;
    n = 0;
    cmdc = 0;
    bad = 1'b0;
    do begin
      @(posedge clk);
      #1 n++;
      seen &= chip_select_n;
      cmdc += w ? !bus_wr_n : !bus_rd_n;
      bad |= w ? !bus_rd_n : !bus_wr_n;
    end while (resp_valid !== 1'b1 && n < 300);
    chk("resp", resp_valid, 1'b1);
    if (stall == 4'h0 || !ready_en) begin
      chk("lat", n, e);
      chk("cmd_len", cmdc, select_timing_reg[s][10:6] + 1);
    end else begin
      chk("stretch", n > e, 1);
    end
    chk("strobe", bad, 1'b0);
    chk("select", seen, 5'(~(5'h1 << s)));
    if (!w) chk("rdata", resp_rdata, shadow[k]);
    prev = s;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      end_of_test();
    end
    if (!rst && bus_ale) chk("strobes", {bus_rd_n, bus_wr_n}, 2'h3);
    if (!rst && !bus_wr_n)
      chk("wdata", {bus_ad_oe, bus_ad_out}, {1'b1, req_wdata});
    if (!rst && (bus_ale || !(&chip_select_n)))
      chk("addr", bus_addr, req_addr);
    if (!rst && mux_mode && bus_ale && !(&chip_select_n))
      chk("mux_addr", {bus_ad_oe, bus_ad_out}, {1'b1, req_addr[15:0]});
  end
  initial begin
    void'($urandom(32'hccb4));
    for (int i = 0; i < NCS; i++) begin
      select_region_base[i] = {i[3:0], 20'h0};
      select_region_mask[i] = 24'hF00000;
      select_timing_reg[i] = tmg(1, 2, 1, 1, 6, 1, 1);
    end
    for (int i = 0; i < 256; i++) shadow[i] = 16'h0;
    repeat (16) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 8; i++)
      acc({4'(i % 3), 16'h0, 4'(i)}, i[0], i % 2);
    // Regions were set above; the lowest region stays with select 0.
    select_function_en = 5'h1E;
    select_timing_reg[2] = tmg(3, 2, 3, 1, 32, 3, 3);
    select_timing_reg[3] = tmg(0, 1, 0, 0, 1, 0, 0);
    acc(24'h200005, 1, 0);
    acc(24'h200005, 0, 0);
    acc(24'h300005, 1, 3);
    acc(24'h800001, 0, 0);
    for (int i = 1; i < NCS; i++)
      select_timing_reg[i] = tmg($urandom % 4, 1 + $urandom % 2,
        $urandom % 4, $urandom % 2, 4 + $urandom % 5, $urandom % 4,
        $urandom % 4);
    for (int j = 0; j < 60; j++) begin
      mux_mode = 1'($urandom);
      ready_en = 1'($urandom);
      stall = ($urandom % 2) ? 4'hC : 4'h0;
      acc({4'($urandom % 6), 16'h0, 4'($urandom)}, 1'($urandom), $urandom % 4);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
